// *** verilog/lut_logic_cfg.svh ***
// holds the register map, field positions and reset values of the lookup logic
// assumes it is included by bare name from the design files
`ifndef LUT_LOGIC_CFG_SVH
`define LUT_LOGIC_CFG_SVH

// ****************************************
// register addresses
// ****************************************
`define ADDR_UPPER_BANK_LOGIC_MODE 8'h20
`define ADDR_LOWER_BANK_LOGIC_MODE 8'h21
`define ADDR_UPPER_BANK_TWO_INPUT_TABLE 8'h22
`define ADDR_LOWER_BANK_TWO_INPUT_TABLE 8'h23
`define ADDR_UPPER_BANK_HIGH_THREE_INPUT_TABLE 8'h24
`define ADDR_LOWER_BANK_HIGH_THREE_INPUT_TABLE 8'h25
`define ADDR_UPPER_BANK_LOW_THREE_INPUT_TABLE 8'h26
`define ADDR_LOWER_BANK_LOW_THREE_INPUT_TABLE 8'h27
`define ADDR_UPPER_BANK_DUAL_OUT_TABLE_FIRST 8'h28
`define ADDR_LOWER_BANK_DUAL_OUT_TABLE_FIRST 8'h29
`define ADDR_UPPER_BANK_DUAL_OUT_TABLE_SECOND 8'h2A
`define ADDR_LOWER_BANK_DUAL_OUT_TABLE_SECOND 8'h2B

// ****************************************
// register file shape
// ****************************************
`define LUT_REG_BASE 8'h20
`define LUT_REG_COUNT 12
`define LUT_REG_RESET 8'h00
`define IDX_MODE_B 0
`define IDX_MODE_A 1
`define IDX_TWO_B 2
`define IDX_TWO_A 3
`define IDX_HI3_B 4
`define IDX_HI3_A 5
`define IDX_LO3_B 6
`define IDX_LO3_A 7
`define IDX_DUAL1_B 8
`define IDX_DUAL1_A 9
`define IDX_DUAL2_B 10
`define IDX_DUAL2_A 11
`define UNMAPPED_READ 8'h00

// ****************************************
// field positions in the mode registers
// ****************************************
`define LO_NIB_MODE_LSB 0
`define HI_NIB_MODE_LSB 4

`endif

// *** verilog/lut_logic_pkg.sv ***
// holds the types shared by the lookup logic files
// assumes nothing of its surroundings
package lut_logic_pkg;

  typedef enum logic [1:0] {
    MODE_GPIO = 2'h0,
    MODE_TWO_TO_ONE = 2'h1,
    MODE_THREE_TO_ONE = 2'h2,
    MODE_THREE_TO_TWO = 2'h3
  } lut_mode_type;

  typedef logic [4:0] nibble_drive_type;

endpackage

// *** verilog/nibble_lut_decode.sv ***
// holds the combinational lookup decode of one nibble of i/o lines
// assumes sampled input levels and stable tables from the owning block
`timescale 1ns/10ps
`default_nettype none

module nibble_lut_decode (
  input wire logic [1:0] mode_i,
  input wire logic [2:0] level_i,
  input wire logic [3:0] two_table_i,
  input wire logic [7:0] three_table_i,
  input wire logic [7:0] dual_first_i,
  input wire logic [7:0] dual_second_i,
  output lut_logic_pkg::nibble_drive_type drive_en_o,
  output lut_logic_pkg::nibble_drive_type drive_val_o
);

  // ****************************************
  // per mode drive, bit 4 is line 0 of the next nibble
  // ****************************************
  always_comb begin
    drive_en_o = 5'h00;
    drive_val_o = 5'h00;
    unique case (lut_logic_pkg::lut_mode_type'(mode_i))
      lut_logic_pkg::MODE_GPIO: begin
        drive_en_o = 5'h00;
      end
      lut_logic_pkg::MODE_TWO_TO_ONE: begin
        drive_en_o[2] = 1'b1;
        drive_val_o[2] = two_table_i[level_i[1:0]];
      end
      lut_logic_pkg::MODE_THREE_TO_ONE: begin
        drive_en_o[3] = 1'b1;
        drive_val_o[3] = three_table_i[level_i];
      end
      lut_logic_pkg::MODE_THREE_TO_TWO: begin
        drive_en_o[4:3] = 2'h3;
        drive_val_o[3] = dual_first_i[level_i];
        drive_val_o[4] = dual_second_i[level_i];
      end
    endcase
  end

endmodule

`default_nettype wire

// *** verilog/gpio_pld_lookup_logic.sv ***
// holds the lookup-table logic of a sixteen line i/o expander with its registers
// assumes a register port from the expander's serial front end, same clock
// What this block does
// - upper bank low mode 11 drives lines 12 and 11 from lines 10:8.
// - lower bank high mode 00 leaves lines 7:5 plain gpio; line 4 follows the low mode.
// - lower bank high mode 01 drives line 6 from table by lines 5:4.
// - lower bank high mode 10 drives line 7 from lines 6:4; 11 reserved.
// - lower bank low mode 00 leaves lines 3:0 plain gpio.
// - lower bank low mode 01 drives line 2 from table by lines 1:0.
// - lower bank low mode 10 drives line 3 from table by lines 2:0.
// - lower bank low mode 11 drives lines 4:3 from two tables by 2:0.
// - upper bank high two-input drives line 14 from table bits 7:4.
// - table bits 7:4 matter only in the high two-input mode of their own bank.
// - upper bank low two-input drives line 10 from table bits 3:0.
// - lower bank high two-input drives line 6 from table bits 7:4.
// - lower bank low two-input gives table bit 3 on line 2 for 11.
// - codes 10, 01, 00 give table bits 2, 1, 0 on line 2.
// - lower bank high three-input gives table bit indexed by lines 6:4.
`timescale 1ns/10ps
`default_nettype none
`include "lut_logic_cfg.svh"

module gpio_pld_lookup_logic (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] io_level_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic [15:0] lut_drive_en_o,
  output logic [15:0] lut_drive_val_o
);

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = (addr >= `LUT_REG_BASE) && (addr < (`LUT_REG_BASE + 8'(`LUT_REG_COUNT)));
  endfunction

  function automatic logic [3:0] addr_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - `LUT_REG_BASE;
    addr_index = diff[3:0];
  endfunction

  logic [7:0] regs_q [`LUT_REG_COUNT];
  logic [15:0] level_meta_q;
  logic [15:0] level_q;
  logic [1:0] mode_nib [4];
  logic [3:0] two_nib [4];
  logic [7:0] three_nib [4];
  logic [7:0] dual1_nib [4];
  logic [7:0] dual2_nib [4];
  lut_logic_pkg::nibble_drive_type en_nib [4];
  lut_logic_pkg::nibble_drive_type val_nib [4];
  logic [15:0] drive_en_d;
  logic [15:0] drive_val_d;

  // ****************************************
  // register file
  // ****************************************
  // writes land in one edge so the decode uses new contents on the next
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < `LUT_REG_COUNT; i++) begin
        regs_q[i] <= `LUT_REG_RESET;
      end
    end else if (reg_wr_i && addr_hit(reg_addr_i)) begin
      // reserved mode bits are stored as written; the decode never reads them
      regs_q[addr_index(reg_addr_i)] <= reg_wdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= `UNMAPPED_READ;
    end else if (reg_rd_i) begin
      reg_rdata_o <= addr_hit(reg_addr_i) ? regs_q[addr_index(reg_addr_i)] : `UNMAPPED_READ;
    end
  end

  // ****************************************
  // pin level synchroniser
  // ****************************************
  // the pads are asynchronous to clock_i, so two stages precede the decode
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      level_meta_q <= 16'h0000;
      level_q <= 16'h0000;
    end else begin
      level_meta_q <= io_level_i;
      level_q <= level_meta_q;
    end
  end

  // ****************************************
  // table routing per nibble
  // ****************************************
  always_comb begin
    mode_nib[0] = regs_q[`IDX_MODE_A][`LO_NIB_MODE_LSB +: 2];
    mode_nib[1] = regs_q[`IDX_MODE_A][`HI_NIB_MODE_LSB +: 2];
    mode_nib[2] = regs_q[`IDX_MODE_B][`LO_NIB_MODE_LSB +: 2];
    mode_nib[3] = regs_q[`IDX_MODE_B][`HI_NIB_MODE_LSB +: 2];
    // upper nibble code 11 is reserved and falls back to plain gpio
    if (mode_nib[1] == 2'h3) begin
      mode_nib[1] = 2'h0;
    end
    if (mode_nib[3] == 2'h3) begin
      mode_nib[3] = 2'h0;
    end
    two_nib[0] = regs_q[`IDX_TWO_A][3:0];
    two_nib[1] = regs_q[`IDX_TWO_A][7:4];
    two_nib[2] = regs_q[`IDX_TWO_B][3:0];
    two_nib[3] = regs_q[`IDX_TWO_B][7:4];
    three_nib[0] = regs_q[`IDX_LO3_A];
    three_nib[1] = regs_q[`IDX_HI3_A];
    three_nib[2] = regs_q[`IDX_LO3_B];
    three_nib[3] = regs_q[`IDX_HI3_B];
    dual1_nib[0] = regs_q[`IDX_DUAL1_A];
    dual1_nib[1] = 8'h00;
    dual1_nib[2] = regs_q[`IDX_DUAL1_B];
    dual1_nib[3] = 8'h00;
    dual2_nib[0] = regs_q[`IDX_DUAL2_A];
    dual2_nib[1] = 8'h00;
    dual2_nib[2] = regs_q[`IDX_DUAL2_B];
    dual2_nib[3] = 8'h00;
  end

  // ****************************************
  // nibble decoders
  // ****************************************
  for (genvar n = 0; n < 4; n++) begin : g_nib
    nibble_lut_decode u_dec (
      .mode_i(mode_nib[n]),
      .level_i(level_q[4*n +: 3]),
      .two_table_i(two_nib[n]),
      .three_table_i(three_nib[n]),
      .dual_first_i(dual1_nib[n]),
      .dual_second_i(dual2_nib[n]),
      .drive_en_o(en_nib[n]),
      .drive_val_o(val_nib[n])
    );
  end

  // a low nibble in dual-output mode reaches into line 0 of the next nibble;
  // no mode of that nibble drives its line 0, so the two never collide
  always_comb begin
    drive_en_d = 16'h0000;
    drive_val_d = 16'h0000;
    for (int n = 0; n < 4; n++) begin
      drive_en_d[4*n +: 4] = drive_en_d[4*n +: 4] | en_nib[n][3:0];
      drive_val_d[4*n +: 4] = drive_val_d[4*n +: 4] | val_nib[n][3:0];
    end
    // the top nibble has no neighbour, so its carry bit is dropped
    for (int n = 0; n < 3; n++) begin
      drive_en_d[4*n+4] = drive_en_d[4*n+4] | en_nib[n][4];
      drive_val_d[4*n+4] = drive_val_d[4*n+4] | val_nib[n][4];
    end
  end

  // one register stage keeps the outputs glitch free at a cost of one cycle
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lut_drive_en_o <= 16'h0000;
      lut_drive_val_o <= 16'h0000;
    end else begin
      lut_drive_en_o <= drive_en_d;
      lut_drive_val_o <= drive_val_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_lo_two_a: assert property ($past(regs_q[`IDX_MODE_A][1:0]) == 2'h1 |->
    lut_drive_en_o[2] && lut_drive_val_o[2] == $past(regs_q[`IDX_TWO_A][level_q[1:0]]))
    else $error("line 2 two-input decode wrong");
  lo_top_code_a: assert property ($past(regs_q[`IDX_MODE_A][1:0]) == 2'h1
    && $past(level_q[1:0]) == 2'h3 |-> lut_drive_val_o[2] == $past(regs_q[`IDX_TWO_A][3]))
    else $error("line 2 not table bit 3 for code 11");
  hi_two_a: assert property ($past(regs_q[`IDX_MODE_A][5:4]) == 2'h1 |->
    lut_drive_en_o[6] && lut_drive_val_o[6] == $past(regs_q[`IDX_TWO_A][{1'b1, level_q[5:4]}]))
    else $error("line 6 two-input decode wrong");
  lo_three_a: assert property ($past(regs_q[`IDX_MODE_A][1:0]) == 2'h2 |->
    lut_drive_en_o[3] && lut_drive_val_o[3] == $past(regs_q[`IDX_LO3_A][level_q[2:0]]))
    else $error("line 3 three-input decode wrong");
  hi_three_a: assert property ($past(regs_q[`IDX_MODE_A][5:4]) == 2'h2 |->
    lut_drive_en_o[7] && lut_drive_val_o[7] == $past(regs_q[`IDX_HI3_A][level_q[6:4]]))
    else $error("line 7 three-input decode wrong");
  dual_out_a: assert property ($past(regs_q[`IDX_MODE_A][1:0]) == 2'h3 |->
    lut_drive_en_o[4:3] == 2'h3
    && lut_drive_val_o[3] == $past(regs_q[`IDX_DUAL1_A][level_q[2:0]])
    && lut_drive_val_o[4] == $past(regs_q[`IDX_DUAL2_A][level_q[2:0]]))
    else $error("lines 4:3 dual decode wrong");
  dual_out_b_a: assert property ($past(regs_q[`IDX_MODE_B][1:0]) == 2'h3 |->
    lut_drive_en_o[12:11] == 2'h3
    && lut_drive_val_o[11] == $past(regs_q[`IDX_DUAL1_B][level_q[10:8]])
    && lut_drive_val_o[12] == $past(regs_q[`IDX_DUAL2_B][level_q[10:8]]))
    else $error("lines 12:11 dual decode wrong");
  b_hi_two_a: assert property ($past(regs_q[`IDX_MODE_B][5:4]) == 2'h1 |->
    lut_drive_en_o[14] && lut_drive_val_o[14] == $past(regs_q[`IDX_TWO_B][{1'b1, level_q[13:12]}]))
    else $error("line 14 two-input decode wrong");
  b_hi_idle_a: assert property ($past(regs_q[`IDX_MODE_B][5:4]) != 2'h1 |->
    !lut_drive_en_o[14])
    else $error("line 14 driven outside two-input mode");
  b_lo_two_a: assert property ($past(regs_q[`IDX_MODE_B][1:0]) == 2'h1 |->
    lut_drive_en_o[10] && lut_drive_val_o[10] == $past(regs_q[`IDX_TWO_B][{1'b0, level_q[9:8]}]))
    else $error("line 10 two-input decode wrong");
  a_gpio_idle_a: assert property ($past(regs_q[`IDX_MODE_A]) == 8'h00 |->
    lut_drive_en_o[7:0] == 8'h00)
    else $error("lower bank driven in gpio mode");
  write_acts_a: assert property (reg_wr_i && reg_addr_i == `ADDR_LOWER_BANK_LOGIC_MODE
    |=> regs_q[`IDX_MODE_A] == $past(reg_wdata_i))
    else $error("mode write not taken in one edge");
  reset_idle_a: assert property ($fell(sys_rst_i) |->
    lut_drive_en_o == 16'h0000 && regs_q[`IDX_MODE_A] == 8'h00)
    else $error("lines driven right after reset");
  reset_regs_a: assert property ($fell(sys_rst_i) |->
    regs_q[`IDX_MODE_B] == 8'h00 && regs_q[`IDX_TWO_A] == 8'h00
    && reg_rdata_o == `UNMAPPED_READ)
    else $error("registers not cleared by reset");

  // ****************************************
  // checks on lines left to plain gpio
  // ****************************************
  // line 4 and line 12 belong to the dual modes of the lower nibbles only
  a_lo_idle_a: assert property ($past(regs_q[`IDX_MODE_A][1:0]) == 2'h0 |->
    lut_drive_en_o[3:0] == 4'h0)
    else $error("lines 3:0 driven in gpio mode");
  a_hi_idle_a: assert property ($past(regs_q[`IDX_MODE_A][5:4]) == 2'h0 |->
    lut_drive_en_o[7:5] == 3'h0)
    else $error("lines 7:5 driven in gpio mode");
  a_hi_reserved_a: assert property ($past(regs_q[`IDX_MODE_A][5:4]) == 2'h3 |->
    lut_drive_en_o[7:5] == 3'h0)
    else $error("lines 7:5 driven under reserved code");
  line_four_a: assert property ($past(regs_q[`IDX_MODE_A][1:0]) != 2'h3 |->
    !lut_drive_en_o[4])
    else $error("line 4 driven outside dual mode");
  line_twelve_a: assert property ($past(regs_q[`IDX_MODE_B][1:0]) != 2'h3 |->
    !lut_drive_en_o[12])
    else $error("line 12 driven outside dual mode");
  b_lo_idle_a: assert property ($past(regs_q[`IDX_MODE_B][1:0]) == 2'h0 |->
    lut_drive_en_o[11:8] == 4'h0)
    else $error("lines 11:8 driven in gpio mode");
  b_hi_reserved_a: assert property ($past(regs_q[`IDX_MODE_B][5:4]) == 2'h3 |->
    lut_drive_en_o[15:13] == 3'h0)
    else $error("lines 15:13 driven under reserved code");
  b_gpio_idle_a: assert property ($past(regs_q[`IDX_MODE_B]) == 8'h00 |->
    lut_drive_en_o[15:8] == 8'h00)
    else $error("upper bank driven in gpio mode");
  val_masked_a: assert property (
    (lut_drive_val_o & ~lut_drive_en_o) == 16'h0000)
    else $error("value shown on a line not driven");

  // ****************************************
  // checks on the upper bank three-input decodes
  // ****************************************
  b_hi_three_a: assert property ($past(regs_q[`IDX_MODE_B][5:4]) == 2'h2 |->
    lut_drive_en_o[15] && lut_drive_val_o[15] == $past(regs_q[`IDX_HI3_B][level_q[14:12]]))
    else $error("line 15 three-input decode wrong");
  b_lo_three_a: assert property ($past(regs_q[`IDX_MODE_B][1:0]) == 2'h2 |->
    lut_drive_en_o[11] && lut_drive_val_o[11] == $past(regs_q[`IDX_LO3_B][level_q[10:8]]))
    else $error("line 11 three-input decode wrong");

  // ****************************************
  // checks on the register port and the pin synchroniser
  // ****************************************
  // the guard skips the two edges where the stages still hold reset values
  sync_delay_a: assert property (!$past(sys_rst_i) && !$past(sys_rst_i, 2) |->
    level_q == $past(io_level_i, 2))
    else $error("pad levels not two stages behind");
  read_back_a: assert property (reg_rd_i && addr_hit(reg_addr_i) |=>
    reg_rdata_o == $past(regs_q[addr_index(reg_addr_i)]))
    else $error("read data not the register contents");
  unmapped_read_a: assert property (reg_rd_i && !addr_hit(reg_addr_i) |=>
    reg_rdata_o == `UNMAPPED_READ)
    else $error("unmapped read not zero");
  // the host may fetch late, so a result stands until the next read
  read_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  table_write_a: assert property (reg_wr_i
    && reg_addr_i == `ADDR_LOWER_BANK_TWO_INPUT_TABLE
    |=> regs_q[`IDX_TWO_A] == $past(reg_wdata_i))
    else $error("table write not taken in one edge");
  stray_write_a: assert property (reg_wr_i && !addr_hit(reg_addr_i) |=>
    regs_q[`IDX_MODE_B] == $past(regs_q[`IDX_MODE_B]))
    else $error("unmapped write changed a mode register");

  c_dual_a: cover property (lut_drive_en_o[4:3] == 2'h3);
  c_three_b: cover property ($past(regs_q[`IDX_MODE_B][5:4]) == 2'h2 && lut_drive_en_o[15]);
  c_two_a: cover property (lut_drive_en_o[2] && lut_drive_en_o[6]);
  c_read_back: cover property (reg_rd_i && reg_addr_i == `ADDR_LOWER_BANK_TWO_INPUT_TABLE);
  c_three_lo_b: cover property ($past(regs_q[`IDX_MODE_B][1:0]) == 2'h2 && lut_drive_en_o[11]);

endmodule

`default_nettype wire

// *** tb/host_model.sv ***
// host model that writes and reads the lookup registers over the strobe port
// assumes the lookup block shares its clock and samples strobes on rising edges
`timescale 1ns/10ps
`default_nettype none

module host_model (
  input wire logic clock_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i
);
  // ****
  // bus cycles
  // ****
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 8'h20 || a == 8'h21) begin
      v = v & 8'h33; // reserved mode bits stay zero
    end
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_wdata_o <= v;
    reg_wr_o <= 1'b1;
    @(posedge clock_i);
    reg_wr_o <= 1'b0;
    // released data shows no stale value
    reg_wdata_o <= ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clock_i);
    reg_rd_o <= 1'b0;
    #1;
    q = reg_rdata_i;
  endtask
endmodule

`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the lookup logic: register access and line decode
// assumes the host model drives the register port and the bench the pad levels
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [15:0] io_level = 16'h0000;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [15:0] drive_en;
  logic [15:0] drive_val;
  logic [7:0] q;
  int n_errors = 0;
  int samples_checked = 0;

  always #5 clock_i = ~clock_i;

  host_model host_model_i (
    .clock_i(clock_i),
    .reg_addr_o(reg_addr),
    .reg_wr_o(reg_wr),
    .reg_wdata_o(reg_wdata),
    .reg_rd_o(reg_rd),
    .reg_rdata_i(reg_rdata)
  );

  gpio_pld_lookup_logic gpio_pld_lookup_logic_i (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .io_level_i(io_level),
    .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr),
    .reg_wdata_i(reg_wdata),
    .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata),
    .lut_drive_en_o(drive_en),
    .lut_drive_val_o(drive_val)
  );

  // ****
  // helpers
  // ****
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // waits out the two sync flops and the output register, plus one spare
  task automatic settle(input logic [15:0] lv);
    @(posedge clock_i);
    io_level <= lv;
    repeat (4) @(posedge clock_i);
    #1;
  endtask

  task automatic sweep(input int lsb, input int n, input int ln, input logic [7:0] t);
    for (int i = 0; i < (1 << n); i++) begin
      settle(16'(i) << lsb);
      check({6'h00, drive_en[ln], drive_val[ln]}, {6'h00, 1'b1, t[i]});
    end
  endtask

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****
  // tests
  // ****
  initial begin
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    for (int a = 32; a < 44; a++) begin
      host_model_i.rd(8'(a), q);
      check(q, 8'h00);
    end
    check(drive_en[7:0] | drive_en[15:8], 8'h00);
    host_model_i.wr(8'h30, 8'hFF);
    host_model_i.rd(8'h30, q);
    check(q, 8'h00);
    host_model_i.wr(8'h23, 8'hA6);
    host_model_i.rd(8'h23, q);
    check(q, 8'hA6);
    host_model_i.wr(8'h21, 8'h01);
    sweep(0, 2, 2, 8'hA6);
    // table rewrite with select lines held at 11
    host_model_i.wr(8'h23, 8'h59);
    repeat (2) @(posedge clock_i);
    #1;
    check({7'h00, drive_val[2]}, 8'h01);
    host_model_i.wr(8'h21, 8'h10);
    sweep(4, 2, 6, 8'h05);
    check({4'h0, drive_en[3:0]}, 8'h00);
    host_model_i.wr(8'h25, 8'h96);
    host_model_i.wr(8'h21, 8'h20);
    sweep(4, 3, 7, 8'h96);
    host_model_i.wr(8'h21, 8'h30);
    settle(16'h0070);
    check({4'h0, drive_en[7:4]}, 8'h00);
    host_model_i.wr(8'h21, 8'h00);
    settle(16'h00FF);
    check(drive_en[7:0], 8'h00);
    host_model_i.wr(8'h27, 8'h3C);
    host_model_i.wr(8'h21, 8'h02);
    sweep(0, 3, 3, 8'h3C);
    host_model_i.wr(8'h29, 8'hE1);
    host_model_i.wr(8'h2B, 8'h4B);
    host_model_i.wr(8'h21, 8'h03);
    sweep(0, 3, 3, 8'hE1);
    sweep(0, 3, 4, 8'h4B);
    host_model_i.wr(8'h22, 8'h5C);
    host_model_i.wr(8'h20, 8'h01);
    settle(16'h3000);
    check({4'h0, drive_en[15:12]}, 8'h00);
    sweep(8, 2, 10, 8'h0C);
    host_model_i.wr(8'h20, 8'h11);
    sweep(12, 2, 14, 8'h05);
    host_model_i.wr(8'h28, 8'h69);
    host_model_i.wr(8'h2A, 8'h87);
    host_model_i.wr(8'h20, 8'h03);
    sweep(8, 3, 11, 8'h69);
    sweep(8, 3, 12, 8'h87);
    // upper bank three-input decodes, then its reserved upper code
    host_model_i.wr(8'h24, 8'hC5);
    host_model_i.wr(8'h26, 8'h3A);
    host_model_i.wr(8'h20, 8'h22);
    sweep(12, 3, 15, 8'hC5);
    sweep(8, 3, 11, 8'h3A);
    host_model_i.wr(8'h20, 8'h30);
    settle(16'h7000);
    check({4'h0, drive_en[15:12]}, 8'h00);
    // second reset in mid-run
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    host_model_i.rd(8'h20, q);
    check(q, 8'h00);
    check(drive_en[15:8], 8'h00);
    tally_and_finish();
  end

  // cuts a hang short; the tests need well under 2000 cycles
  initial begin
    #100us;
    n_errors++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
